// file: rtl/liu_config_register_bank.sv
`include "liu_params.svh"
module liu_config_register_bank #(
  parameter logic [7:0] CHIP_ID = 8'h5a  // arbitrary identity value
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic [7:0]              hostAddr,
  input  wire logic                    hostWrite,
  input  wire logic                    hostRead,
  input  wire liu_pkg::liu_byte_t      hostWrData,
  output liu_pkg::liu_byte_t           hostRdData,
  output logic                         hostRdValid,
  input  wire logic [7:0]              irqSourcePending,
  input  wire logic [1:0]              auxPinIn,
  output logic [1:0]                   auxPinOut,
  output logic [1:0]                   auxPinOutEn,
  output logic                         irqPinOut,
  output logic                         irqPinOutEn,
  output logic                         lineStandardT1,
  output logic [3:0]                   observeSel,
  output logic                         observeEnable,
  output logic [7:0][5:0]              chanJitterCfg,
  output logic [7:0][4:0]              chanTxCfg0,
  output logic [7:0][5:0]              chanTxCfg1,
  output logic [7:0][5:0]              chanPulseScale,
  output logic [7:0][4:0]              chanRxCfg0,
  output logic [7:0]                   lineDriverHiZ,
  output logic [7:0]                   attenInTx,
  output logic [7:0]                   attenInRx,
  input  wire logic [2:0]              tplRdChan,
  input  wire logic [5:0]              tplRdAddr,
  output logic [6:0]                   tplRdData
);
  import liu_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [4:0]       global_config_0_r;            // global config 0
  logic [7:0]       irqChanFlags_r;    // per-channel interrupt flags
  logic [1:0]       auxDir_r;          // 1 = pin is an input
  logic [1:0]       auxLevel_r;        // drive level for outputs
  logic             softRst_r;         // write to reset address seen
  logic [7:0][7:0]  chanRamAcc;        // indirect access control
  logic [7:0][6:0]  chanRamData;       // indirect access data
  logic [6:0]       tplRam [0:511];    // template samples, 64 per channel
  logic             isGlobal;          // low address bits all zero
  liu_byte_t        rdMux;             // read data before the flop
  liu_irqpin_e      irqMode;           // interrupt pin mode
  logic             irqActive;         // interrupt wanted on the pin

  assign isGlobal = (hostAddr[4:0] == 5'h00);
  assign irqMode  = liu_irqpin_e'(global_config_0_r[1:0]);

  // write strobe for one channel register, broadcast aware
  function automatic logic chanWr(input logic [2:0] ch, input logic [4:0] ofs);
    chanWr = hostWrite && !isGlobal && (hostAddr[4:0] == ofs)
             && (global_config_0_r[`LIU_GC0_COPY] || (hostAddr[7:5] == ch));
  endfunction

  // attenuator placement decode, shared by both path outputs
  function automatic logic attenIs(input logic [5:0] cfg, input liu_atten_e p);
    attenIs = (liu_atten_e'(cfg[4:3]) == p);
  endfunction

  // ************************************************************
  // software reset strobe
  // ************************************************************
  // a write to the reset address restores defaults one cycle later
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      softRst_r <= 1'b0;
    else
      softRst_r <= hostWrite && (hostAddr == `LIU_ADDR_SWRST);
  end

  // ************************************************************
  // global registers
  // ************************************************************
  // global config 0, config 1 and the aux pin register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      global_config_0_r     <= `LIU_RST_GLOBAL_CONFIG_0;
      observeSel <= `LIU_RST_GLOBAL_CONFIG_1;
      auxDir_r   <= `LIU_RST_AUXDIR;
      auxLevel_r <= 2'h0;
    end
    else if (softRst_r)
    begin
      global_config_0_r     <= `LIU_RST_GLOBAL_CONFIG_0;
      observeSel <= `LIU_RST_GLOBAL_CONFIG_1;
      auxDir_r   <= `LIU_RST_AUXDIR;
      auxLevel_r <= 2'h0;
    end
    else if (hostWrite)
    begin
      // only defined bits are kept, reserved bits drop
      if (hostAddr == `LIU_ADDR_GLOBAL_CONFIG_0)
        global_config_0_r <= hostWrData[4:0];
      if (hostAddr == `LIU_ADDR_GLOBAL_CONFIG_1)
        observeSel <= hostWrData[7:4];
      if (hostAddr == `LIU_ADDR_AUX)
      begin
        auxDir_r   <= hostWrData[1:0];
        auxLevel_r <= hostWrData[3:2];
      end
    end
  end

  // decoded global outputs; codes x000 mean no monitoring
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      lineStandardT1 <= 1'b0;
      observeEnable  <= 1'b0;
    end
    else
    begin
      lineStandardT1 <= global_config_0_r[`LIU_GC0_STD];
      observeEnable  <= (observeSel[2:0] != 3'h0);
    end
  end

  // ************************************************************
  // interrupt flags and pin
  // ************************************************************
  // flags track the pending sources, so they clear when the
  // channel status is acknowledged outside this block
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      irqChanFlags_r <= `LIU_RST_IRQCH;
    else if (softRst_r)
      irqChanFlags_r <= `LIU_RST_IRQCH;
    else
      irqChanFlags_r <= irqSourcePending;
  end

  assign irqActive = (|irqChanFlags_r) && !global_config_0_r[`LIU_GC0_IRQDIS];

  // pin drive per mode; enable low means this end drives
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      irqPinOut   <= 1'b0;
      irqPinOutEn <= 1'b1;
    end
    else
    begin
      unique case (irqMode)
        LIU_IRQ_OD0, LIU_IRQ_OD2:
        begin
          // open drain: pull low only, pull-up gives the high
          irqPinOut   <= 1'b0;
          irqPinOutEn <= !irqActive;
        end
        LIU_IRQ_PPL:
        begin
          irqPinOut   <= !irqActive;
          irqPinOutEn <= 1'b0;
        end
        LIU_IRQ_PPH:
        begin
          irqPinOut   <= irqActive;
          irqPinOutEn <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // aux pins
  // ************************************************************
  // input direction releases the pin
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      auxPinOut   <= 2'h0;
      auxPinOutEn <= 2'h3;
    end
    else
    begin
      auxPinOut   <= auxLevel_r;
      auxPinOutEn <= auxDir_r;
    end
  end

  // ************************************************************
  // per-channel configuration
  // ************************************************************
  // one loop writes every channel; broadcast lives in chanWr
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int c = 0; c < 8; c++)
      begin
        chanJitterCfg[c]  <= `LIU_RST_JITTER;
        chanTxCfg0[c]     <= `LIU_RST_TX0;
        chanTxCfg1[c]     <= `LIU_RST_TX1;
        chanPulseScale[c] <= `LIU_RST_SCALE;
        chanRxCfg0[c]     <= `LIU_RST_RX0;
      end
    end
    else
    begin
      for (int c = 0; c < 8; c++)
      begin
        if (softRst_r)
        begin
          chanJitterCfg[c]  <= `LIU_RST_JITTER;
          chanTxCfg0[c]     <= `LIU_RST_TX0;
          chanTxCfg1[c]     <= `LIU_RST_TX1;
          chanPulseScale[c] <= `LIU_RST_SCALE;
          chanRxCfg0[c]     <= `LIU_RST_RX0;
        end
        else
        begin
          // fields exported raw to the line logic
          if (chanWr(3'(c), `LIU_OFS_JITTER))
            chanJitterCfg[c] <= hostWrData[5:0];
          if (chanWr(3'(c), `LIU_OFS_TX0))
            chanTxCfg0[c] <= hostWrData[4:0];
          if (chanWr(3'(c), `LIU_OFS_TX1))
            chanTxCfg1[c] <= hostWrData[5:0];
          if (chanWr(3'(c), `LIU_OFS_SCALE))
            chanPulseScale[c] <= hostWrData[5:0];
          if (chanWr(3'(c), `LIU_OFS_RX0))
            chanRxCfg0[c] <= hostWrData[4:0];
        end
      end
    end
  end

  // driver high-z and attenuator placement, decoded per channel
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      lineDriverHiZ <= 8'hff;
      attenInTx     <= 8'h00;
      attenInRx     <= 8'h00;
    end
    else
    begin
      for (int c = 0; c < 8; c++)
      begin
        // power-down also floats the driver
        lineDriverHiZ[c] <= chanTxCfg0[c][`LIU_TX0_PWDN]
                            || chanTxCfg1[c][`LIU_TX1_HIZ];
        attenInTx[c] <= attenIs(chanJitterCfg[c], LIU_JA_TX);
        attenInRx[c] <= attenIs(chanJitterCfg[c], LIU_JA_RX);
      end
    end
  end

  // ************************************************************
  // indirect template access
  // ************************************************************
  // go bit holds one cycle, during which the access runs;
  // a host write in the same cycle wins over the self-clear
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int c = 0; c < 8; c++)
      begin
        chanRamAcc[c]  <= `LIU_RST_RAMACC;
        chanRamData[c] <= `LIU_RST_RAMDATA;
      end
    end
    else
    begin
      for (int c = 0; c < 8; c++)
      begin
        if (softRst_r)
        begin
          chanRamAcc[c]  <= `LIU_RST_RAMACC;
          chanRamData[c] <= `LIU_RST_RAMDATA;
        end
        else
        begin
          if (chanWr(3'(c), `LIU_OFS_RAMACC))
            chanRamAcc[c] <= hostWrData;
          else if (chanRamAcc[c][`LIU_ACC_GO])
            chanRamAcc[c][`LIU_ACC_GO] <= 1'b0;
          if (chanWr(3'(c), `LIU_OFS_RAMDATA))
            chanRamData[c] <= hostWrData[6:0];
          else if (chanRamAcc[c][`LIU_ACC_GO] && chanRamAcc[c][`LIU_ACC_DIR])
            chanRamData[c] <= tplRam[{3'(c), chanRamAcc[c][5:0]}];
        end
      end
    end
  end

  // template RAM has no reset; contents are undefined until written
  always_ff @(posedge clock)
  begin
    for (int c = 0; c < 8; c++)
    begin
      if (chanRamAcc[c][`LIU_ACC_GO] && !chanRamAcc[c][`LIU_ACC_DIR])
        tplRam[{3'(c), chanRamAcc[c][5:0]}] <= chanRamData[c];
    end
  end

  // shaper read port, one cycle of latency
  always_ff @(posedge clock)
  begin
    tplRdData <= tplRam[{tplRdChan, tplRdAddr}];
  end

  // ************************************************************
  // host read path
  // ************************************************************
  // unmapped addresses and reserved bits read as zero
  always_comb
  begin
    rdMux = 8'h00;
    if (isGlobal)
    begin
      unique case (hostAddr[7:5])
        3'h0: rdMux = CHIP_ID;
        3'h2: rdMux = {3'h0, global_config_0_r};
        3'h3: rdMux = {observeSel, 4'h0};
        3'h4: rdMux = irqChanFlags_r;
        3'h5:
        begin
          // inputs show the pin, outputs show the drive level
          rdMux[3] = auxDir_r[1] ? auxPinIn[1] : auxLevel_r[1];
          rdMux[2] = auxDir_r[0] ? auxPinIn[0] : auxLevel_r[0];
          rdMux[1:0] = auxDir_r;
        end
        default: rdMux = 8'h00;
      endcase
    end
    else
    begin
      unique case (hostAddr[4:0])
        `LIU_OFS_JITTER:  rdMux = {2'h0, chanJitterCfg[hostAddr[7:5]]};
        `LIU_OFS_TX0:     rdMux = {3'h0, chanTxCfg0[hostAddr[7:5]]};
        `LIU_OFS_TX1:     rdMux = {2'h0, chanTxCfg1[hostAddr[7:5]]};
        `LIU_OFS_SCALE:   rdMux = {2'h0, chanPulseScale[hostAddr[7:5]]};
        `LIU_OFS_RAMACC:  rdMux = chanRamAcc[hostAddr[7:5]];
        `LIU_OFS_RAMDATA: rdMux = {1'b0, chanRamData[hostAddr[7:5]]};
        `LIU_OFS_RX0:     rdMux = {3'h0, chanRxCfg0[hostAddr[7:5]]};
        default:          rdMux = 8'h00;
      endcase
    end
  end

  // read data registered, valid for one cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      hostRdData  <= 8'h00;
      hostRdValid <= 1'b0;
    end
    else
    begin
      hostRdValid <= hostRead;
      if (hostRead)
        hostRdData <= rdMux;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_stdWrite;
    hostWrite && (hostAddr == `LIU_ADDR_GLOBAL_CONFIG_0) && !softRst_r;
  endsequence
  property p_stdSel;
    @(posedge clock) disable iff (reset)
    s_stdWrite |=> ##1 lineStandardT1 == $past(hostWrData[`LIU_GC0_STD], 2);
  endproperty
  a_stdSel: assert property (p_stdSel) else $error("standard bit lost");

  property p_bcast;
    @(posedge clock) disable iff (reset)
    hostWrite && !softRst_r && global_config_0_r[`LIU_GC0_COPY] && (hostAddr[4:0] == `LIU_OFS_TX0)
    |=> chanTxCfg0[0] == $past(hostWrData[4:0])
        && chanTxCfg0[7] == $past(hostWrData[4:0]);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not copied");

  property p_irqDis;
    @(posedge clock) disable iff (reset)
    global_config_0_r[`LIU_GC0_IRQDIS] && (irqMode == LIU_IRQ_PPH) |=> !irqPinOut;
  endproperty
  a_irqDis: assert property (p_irqDis) else $error("irq not blocked");

  property p_odMode;
    @(posedge clock) disable iff (reset)
    !irqMode[0] |=> !irqPinOut && (irqPinOutEn == !$past(irqActive));
  endproperty
  a_odMode: assert property (p_odMode) else $error("open drain drive wrong");

  property p_observe;
    @(posedge clock) disable iff (reset)
    ##1 observeEnable == ($past(observeSel[2:0]) != 3'h0);
  endproperty
  a_observe: assert property (p_observe) else $error("observe enable wrong");

  property p_flags;
    @(posedge clock) disable iff (reset)
    !softRst_r |=> irqChanFlags_r == $past(irqSourcePending);
  endproperty
  a_flags: assert property (p_flags) else $error("channel flags stale");

  property p_auxIn;
    @(posedge clock) disable iff (reset)
    auxDir_r[0] |=> auxPinOutEn[0];
  endproperty
  a_auxIn: assert property (p_auxIn) else $error("input pin driven");

  property p_hiz;
    @(posedge clock) disable iff (reset)
    chanTxCfg0[3][`LIU_TX0_PWDN] |=> lineDriverHiZ[3];
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver not floated");

  sequence s_goRead0;
    chanRamAcc[0][`LIU_ACC_GO] && chanRamAcc[0][`LIU_ACC_DIR] && !softRst_r
    && !chanWr(3'h0, `LIU_OFS_RAMDATA);
  endsequence
  property p_ramRead;
    @(posedge clock) disable iff (reset)
    s_goRead0 |=> chanRamData[0] == $past(tplRam[{3'h0, chanRamAcc[0][5:0]}]);
  endproperty
  a_ramRead: assert property (p_ramRead) else $error("read data wrong");

  property p_goClear;
    @(posedge clock) disable iff (reset)
    chanRamAcc[0][`LIU_ACC_GO] && !chanWr(3'h0, `LIU_OFS_RAMACC)
    |=> !chanRamAcc[0][`LIU_ACC_GO];
  endproperty
  a_goClear: assert property (p_goClear) else $error("go stuck");

endmodule // liu_config_register_bank

// file: rtl/liu_params.svh
`ifndef LIU_PARAMS_SVH
`define LIU_PARAMS_SVH
// ************************************************************
// global addresses (low five address bits all zero)
// ************************************************************
`define LIU_ADDR_ID       8'h00
`define LIU_ADDR_SWRST    8'h20
`define LIU_ADDR_GLOBAL_CONFIG_0     8'h40
`define LIU_ADDR_GLOBAL_CONFIG_1     8'h60
`define LIU_ADDR_IRQCH    8'h80
`define LIU_ADDR_AUX      8'ha0
// ************************************************************
// per-channel offsets, channel base is channel index times 0x20
// ************************************************************
`define LIU_OFS_JITTER    5'h01
`define LIU_OFS_TX0       5'h02
`define LIU_OFS_TX1       5'h03
`define LIU_OFS_SCALE     5'h04
`define LIU_OFS_RAMACC    5'h05
`define LIU_OFS_RAMDATA   5'h06
`define LIU_OFS_RX0       5'h07
// ************************************************************
// field positions
// ************************************************************
`define LIU_GC0_STD       4
`define LIU_GC0_COPY      3
`define LIU_GC0_IRQDIS    2
`define LIU_TX0_PWDN      4
`define LIU_TX1_HIZ       4
`define LIU_ACC_GO        7
`define LIU_ACC_DIR       6
// ************************************************************
// reset values
// ************************************************************
`define LIU_RST_GLOBAL_CONFIG_0      5'h04
`define LIU_RST_GLOBAL_CONFIG_1      4'h0
`define LIU_RST_AUXDIR    2'h3
`define LIU_RST_JITTER    6'h00
`define LIU_RST_TX0       5'h00
`define LIU_RST_TX1       6'h10
`define LIU_RST_SCALE     6'h21
`define LIU_RST_RAMACC    8'h00
`define LIU_RST_RAMDATA   7'h00
`define LIU_RST_RX0       5'h00
`define LIU_RST_IRQCH     8'h00
`endif

// file: rtl/liu_pkg.sv
package liu_pkg;
  // attenuator placement codes
  typedef enum logic [1:0] {
    LIU_JA_OFF0 = 2'b00,
    LIU_JA_TX   = 2'b01,
    LIU_JA_OFF2 = 2'b10,
    LIU_JA_RX   = 2'b11
  } liu_atten_e;
  // interrupt pin drive modes
  typedef enum logic [1:0] {
    LIU_IRQ_OD0 = 2'b00,
    LIU_IRQ_PPL = 2'b01,
    LIU_IRQ_OD2 = 2'b10,
    LIU_IRQ_PPH = 2'b11
  } liu_irqpin_e;
  typedef logic [7:0] liu_byte_t;
endpackage

// file: tb/liu_config_register_bank_tb.sv
module liu_config_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import liu_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  hostAddr, irqPend = 8'h00, hiZ, jaTx, jaRx, a, d;
  logic        hostWrite, hostRead, hostRdValid, irqOut, irqEn, std, obsEn;
  liu_byte_t   hostWrData, hostRdData, rv;
  logic [1:0]  auxIn = 2'b00, auxOut, auxEn;
  logic [3:0]  obsSel;
  logic [2:0]  tChan = 3'h0, ch;
  logic [5:0]  tAddr = 6'h00, ta;
  logic [6:0]  tData;
  logic [4:0]  o;
  logic [4:0]  ofsTab [5] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07};
  int          error_cnt = 0;
  int          tests_run = 0;
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  liu_config_register_bank u_dut (
    .clock(clock), .reset(reset), .hostAddr(hostAddr), .hostWrite(hostWrite),
    .hostRead(hostRead), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .irqSourcePending(irqPend), .auxPinIn(auxIn),
    .auxPinOut(auxOut), .auxPinOutEn(auxEn), .irqPinOut(irqOut), .irqPinOutEn(irqEn),
    .lineStandardT1(std), .observeSel(obsSel), .observeEnable(obsEn),
    .chanJitterCfg(), .chanTxCfg0(), .chanTxCfg1(), .chanPulseScale(), .chanRxCfg0(),
    .lineDriverHiZ(hiZ), .attenInTx(jaTx), .attenInRx(jaRx), .tplRdChan(tChan),
    .tplRdAddr(tAddr), .tplRdData(tData)
  );
  liu_host_model u_host (
    .clock(clock), .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid)
  );
  // ************************************************************
  // expectations and checks
  // ************************************************************
  // writable bits of each channel offset in ofsTab
  function automatic logic [7:0] msk(input logic [4:0] ofs);
    return (ofs == 5'h01 || ofs == 5'h03 || ofs == 5'h04) ? 8'h3f : 8'h1f;
  endfunction
  // pin seen as {driven value, enable}; open drain only pulls low
  function automatic logic [7:0] irqExp(input logic [1:0] m, input logic act);
    if (!m[0])
      return {6'h0, 1'b0, ~act};
    return {6'h0, m[1] ? act : ~act, 1'b0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
    u_host.rd(ad, rv);
    chk(rv, exp);
  endtask
  task automatic give_verdict();
    error_cnt += u_host.tmo;
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (50000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(20));
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    // defaults after power-up reset
    rchk(8'h40, 8'h04);
    rchk(8'h60, 8'h00);
    rchk(8'h80, 8'h00);
    rchk(8'ha0, 8'h03);
    rchk(8'h23, 8'h10);
    rchk(8'he4, 8'h21);
    chk(hiZ, 8'hff);
    // random channel writes, reserved bits must drop
    for (int i = 0; i < 24; i++)
    begin
      ch = 3'($urandom_range(7));
      o = ofsTab[$urandom_range(4)];
      d = 8'($urandom);
      u_host.wr({ch, o}, d);
      rchk({ch, o}, d & msk(o));
    end
    // every placement code
    for (int k = 0; k < 4; k++)
    begin
      a = {3'($urandom_range(7)), 5'h01};
      u_host.wr(a, 8'(k << 3));
      @(negedge clock);
      chk({6'h0, jaTx[a[7:5]], jaRx[a[7:5]]}, {6'h0, k == 1, k == 3});
    end
    // power-down forces driver off even with tristate clear
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h02, 8'h00);
    @(negedge clock);
    chk({7'h0, hiZ[0]}, 8'h00);
    u_host.wr(8'h02, 8'h10);
    @(negedge clock);
    chk({7'h0, hiZ[0]}, 8'h01);
    // broadcast on, then off again
    u_host.wr(8'h40, 8'h08);
    u_host.wr(8'h62, 8'h0b);
    for (int i = 0; i < 8; i++)
      rchk({3'(i), 5'h02}, 8'h0b);
    u_host.wr(8'h40, 8'h00);
    u_host.wr(8'h02, 8'h05);
    rchk(8'h22, 8'h0b);
    // line standard
    u_host.wr(8'h40, 8'h10);
    @(negedge clock);
    chk({7'h0, std}, 8'h01);
    // all observe codes, 0000 and 1000 mean no monitoring
    for (int k = 0; k < 16; k++)
    begin
      u_host.wr(8'h60, 8'(k << 4));
      @(negedge clock);
      chk({3'h0, obsEn, obsSel}, {3'h0, k[2:0] != 3'h0, 4'(k)});
    end
    // interrupt pin in each mode, blocked while disabled
    irqPend = 8'h05;
    for (int m = 0; m < 4; m++)
    begin
      u_host.wr(8'h40, 8'(8'h04 | m));
      repeat (3) @(negedge clock);
      chk({6'h0, irqOut & ~irqEn, irqEn}, irqExp(2'(m), 1'b0));
      u_host.wr(8'h40, 8'(m));
      repeat (3) @(negedge clock);
      chk({6'h0, irqOut & ~irqEn, irqEn}, irqExp(2'(m), 1'b1));
    end
    rchk(8'h80, 8'h05);
    irqPend = 8'h00;
    repeat (3) @(negedge clock);
    chk({6'h0, irqOut & ~irqEn, irqEn}, irqExp(2'b11, 1'b0));
    // aux pins as inputs, then as outputs
    auxIn = 2'($urandom);
    rchk(8'ha0, {4'h0, auxIn, 2'b11});
    u_host.wr(8'ha0, 8'h08);
    @(negedge clock);
    chk({4'h0, auxOut, auxEn}, 8'h08);
    rchk(8'ha0, 8'h08);
    // template store then fetch, data first then go
    d = 8'($urandom) & 8'h7f;
    ta = 6'($urandom);
    u_host.wr(8'h06, d);
    u_host.wr(8'h05, {2'b10, ta});
    repeat (2) @(negedge clock);
    rchk(8'h05, {2'b00, ta});
    tChan = 3'h0;
    tAddr = ta;
    repeat (2) @(negedge clock);
    chk({1'b0, tData}, d);
    u_host.wr(8'h06, ~d & 8'h7f);
    u_host.wr(8'h05, {2'b11, ta});
    repeat (2) @(negedge clock);
    rchk(8'h06, d);
    // software reset restores defaults
    u_host.wr(8'h20, 8'($urandom));
    rchk(8'h40, 8'h04);
    rchk(8'ha0, {4'h0, auxIn, 2'b11});
    rchk(8'h22, 8'h00);
    give_verdict();
  end
endmodule  // liu_config_register_bank_tb

// file: tb/liu_host_model.sv
// ************************************************************
// host side of the register bus, strobes change at falling edges
// ************************************************************
module liu_host_model (
  input  wire logic                 clock,
  output logic [7:0]                hostAddr,
  output logic                      hostWrite,
  output logic                      hostRead,
  output liu_pkg::liu_byte_t        hostWrData,
  input  wire liu_pkg::liu_byte_t   hostRdData,
  input  wire logic                 hostRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  import liu_pkg::*;
  int tmo = 0;  // read waits that ran out
  initial
  begin
    hostAddr = 8'h00;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostWrData = 8'h00;
  end
  // one write strobe, data inverted after so no stale value lingers
  task automatic wr(input logic [7:0] a, input liu_byte_t d);
    @(negedge clock);
    hostAddr = a;
    hostWrData = d;
    hostWrite = 1'b1;
    @(negedge clock);
    hostWrite = 1'b0;
    hostWrData = ~d;
  endtask
  // one read strobe, answer waited for under a bound
  task automatic rd(input logic [7:0] a, output liu_byte_t d);
    int n;
    @(negedge clock);
    hostAddr = a;
    hostRead = 1'b1;
    @(negedge clock);
    hostRead = 1'b0;
    n = 0;
    while (hostRdValid !== 1'b1 && n < 4)
    begin
      @(negedge clock);
      n++;
    end
    if (hostRdValid !== 1'b1) tmo++;
    d = hostRdData;
  endtask
endmodule  // liu_host_model
